// *** hw/reset_seq_map.svh ***
`ifndef RESET_SEQ_MAP_SVH
`define RESET_SEQ_MAP_SVH

// self test length per sysclk ratio, system cycles
`define BIST_CYC_R3 22645
`define BIST_CYC_R4 19722
`define BIST_CYC_R15 13292
// serial load length per sysclk ratio, system cycles
`define LOAD_CYC_R3 4408217
`define LOAD_CYC_R4 3306194
`define LOAD_CYC_R15 881652
// serial clock shape in processor cycles
`define SROM_PERIOD 126
`define SROM_HALF 7'h3F
`define SROM_PHASE_LAST 7'h7D
// counter widths
`define SEQ_W 23
`define WORD_W 8
// clock mode strap codes
`define MODE_NORMAL 3'h5
`define MODE_DIV2 3'h0
`define MODE_CHIPTEST 3'h1
`define MODE_MODTEST 3'h2
`define MODE_CLKRST 3'h3

`endif

// *** hw/reset_seq_pkg.sv ***
`include "reset_seq_map.svh"
package reset_seq_pkg;
	// one-hot sequencing states
	typedef enum logic [3:0] {
		S_HOLD = 4'h1,
		S_BIST = 4'h2,
		S_LOAD = 4'h4,
		S_RUN = 4'h8
	} seq_state_t;

	// complete block state
	typedef struct packed {
		seq_state_t state;
		logic [3:0] ratio;
		logic [3:0] div;
		logic [`SEQ_W-1:0] seq;
		logic [6:0] phase;
		logic [2:0] nbit;
		logic [`WORD_W-1:0] shreg;
		logic [`WORD_W-1:0] buf0;
		logic [`WORD_W-1:0] buf1;
		logic [1:0] fill;
		logic valid;
		logic chip_rst_n;
		logic srom_clk;
		logic [2:0] clk_div;
		logic bypass;
		logic eq_en;
		logic track;
		logic gen_rst;
		logic invalid;
	} seq_regs_t;
endpackage : reset_seq_pkg

// *** hw/reset_bist_srom_clkmode.sv ***
`timescale 1ns/100ps
`include "reset_seq_map.svh"
module reset_bist_srom_clkmode #(
	parameter int BIST_R3 = `BIST_CYC_R3,
	parameter int BIST_R4 = `BIST_CYC_R4,
	parameter int BIST_R15 = `BIST_CYC_R15,
	parameter int LOAD_R3 = `LOAD_CYC_R3,
	parameter int LOAD_R4 = `LOAD_CYC_R4,
	parameter int LOAD_R15 = `LOAD_CYC_R15
) (
	// clock and block reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// system reset and straps
	input wire logic sys_reset_n_i,
	input wire logic srom_present_n_i,
	input wire logic [3:0] sysclk_ratio_i,
	input wire logic [2:0] clk_mode_i,
	// serial boot rom
	input wire logic srom_data_i,
	output logic srom_clk_o,
	// loaded word stream
	output logic load_valid_o,
	output logic [`WORD_W-1:0] load_data_o,
	input wire logic load_ready_i,
	// internal reset
	output logic chip_reset_n_o,
	// clock mode controls
	output logic [2:0] clk_div_o,
	output logic div_bypass_o,
	output logic equalizer_en_o,
	output logic ref_track_o,
	output logic system_clock_output_reset_o,
	output logic clk_mode_invalid_o
);
	reset_seq_pkg::seq_regs_t r_reg; // registered state
	reset_seq_pkg::seq_regs_t r_next; // next state
	logic tick; // last processor cycle of a system cycle
	logic word_done; // serial word completes this cycle
	logic push; // word enters buffer
	logic pop; // receiver takes head word
	logic stall; // buffer full, freeze the load
	logic bist_end; // final self test system cycle
	logic load_end; // final load system cycle
	logic [`WORD_W-1:0] word_in; // assembled word

	// self test length for the captured ratio
	function automatic logic [`SEQ_W-1:0] bist_len(input logic [3:0] ratio);
		unique case (ratio)
			4'h3: bist_len = `SEQ_W'(BIST_R3);
			4'hF: bist_len = `SEQ_W'(BIST_R15);
			default: bist_len = `SEQ_W'(BIST_R4); // unlisted ratios reuse ratio 4
		endcase
	endfunction : bist_len

	// serial load length for the captured ratio
	function automatic logic [`SEQ_W-1:0] load_len(input logic [3:0] ratio);
		unique case (ratio)
			4'h3: load_len = `SEQ_W'(LOAD_R3);
			4'hF: load_len = `SEQ_W'(LOAD_R15);
			default: load_len = `SEQ_W'(LOAD_R4);
		endcase
	endfunction : load_len

	// strap decode: {div, bypass, equalizer, track, gen reset, invalid}
	function automatic logic [7:0] mode_decode(input logic [2:0] mode);
		unique case (mode)
			`MODE_NORMAL: mode_decode = {3'h1, 5'b01000};
			`MODE_DIV2: mode_decode = {3'h2, 5'b00000};
			`MODE_CHIPTEST: mode_decode = {3'h1, 5'b10000};
			`MODE_MODTEST: mode_decode = {3'h4, 5'b00100};
			`MODE_CLKRST: mode_decode = {3'h1, 5'b00010};
			default: mode_decode = {3'h1, 5'b00001};
		endcase
	endfunction : mode_decode

	// shared strobes
	assign tick = (r_reg.div == r_reg.ratio - 4'h1);
	assign word_done = (r_reg.state == reset_seq_pkg::S_LOAD)
		&& (r_reg.phase == `SROM_PHASE_LAST) && (r_reg.nbit == 3'h7);
	assign pop = r_reg.valid && load_ready_i;
	// a full buffer holds the serial clock still rather than drop a word
	assign stall = word_done && (r_reg.fill == 2'h2) && !pop;
	assign push = word_done && !stall;
	assign word_in = {r_reg.shreg[`WORD_W-2:0], srom_data_i};
	assign bist_end = (r_reg.state == reset_seq_pkg::S_BIST) && tick
		&& (r_reg.seq == bist_len(r_reg.ratio) - `SEQ_W'(1));
	assign load_end = (r_reg.state == reset_seq_pkg::S_LOAD) && tick && !stall
		&& (r_reg.seq == load_len(r_reg.ratio) - `SEQ_W'(1));

	// next state
	always_comb begin
		r_next = r_reg;
		// system cycle divider, frozen during a stall
		if (!stall) begin
			r_next.div = tick ? 4'h0 : r_reg.div + 4'h1;
		end
		unique case (r_reg.state)
			reset_seq_pkg::S_HOLD: begin
				// ratio strap is caught while the system holds reset
				r_next.ratio = sysclk_ratio_i;
				r_next.div = 4'h0;
				r_next.seq = '0;
				r_next.chip_rst_n = 1'b0;
				if (sys_reset_n_i) begin
					r_next.state = reset_seq_pkg::S_BIST;
				end
			end
			reset_seq_pkg::S_BIST: begin
				if (tick) begin
					r_next.seq = r_reg.seq + `SEQ_W'(1);
				end
				if (bist_end) begin
					r_next.seq = '0;
					if (srom_present_n_i) begin
						r_next.state = reset_seq_pkg::S_RUN;
						r_next.chip_rst_n = 1'b1;
					end else begin
						r_next.state = reset_seq_pkg::S_LOAD;
						r_next.phase = 7'h00;
						r_next.nbit = 3'h0;
						r_next.srom_clk = 1'b1;
					end
				end
			end
			reset_seq_pkg::S_LOAD: begin
				r_next.chip_rst_n = 1'b0;
				if (!stall) begin
					// fixed 126 cycle serial clock, half high half low
					r_next.phase = (r_reg.phase == `SROM_PHASE_LAST) ? 7'h00 : r_reg.phase + 7'h01;
					r_next.srom_clk = (r_next.phase < `SROM_HALF);
					if (tick) begin
						r_next.seq = r_reg.seq + `SEQ_W'(1);
					end
					// sample at the end of the period, late as possible
					if (r_reg.phase == `SROM_PHASE_LAST) begin
						r_next.shreg = word_in;
						r_next.nbit = r_reg.nbit + 3'h1;
					end
					if (load_end) begin
						r_next.state = reset_seq_pkg::S_RUN;
						r_next.chip_rst_n = 1'b1;
						r_next.srom_clk = 1'b0;
					end
				end
			end
			reset_seq_pkg::S_RUN: begin
				r_next.chip_rst_n = 1'b1;
			end
		endcase
		// two entry buffer toward the receiver
		unique case ({push, pop})
			2'b10: begin
				if (r_reg.fill == 2'h0) begin
					r_next.buf0 = word_in;
				end else begin
					r_next.buf1 = word_in;
				end
				r_next.fill = r_reg.fill + 2'h1;
			end
			2'b01: begin
				r_next.buf0 = r_reg.buf1;
				r_next.fill = r_reg.fill - 2'h1;
			end
			2'b11: begin
				if (r_reg.fill == 2'h1) begin
					r_next.buf0 = word_in;
				end else begin
					r_next.buf0 = r_reg.buf1;
					r_next.buf1 = word_in;
				end
			end
			default: begin
				r_next.fill = r_reg.fill;
			end
		endcase
		r_next.valid = (r_next.fill != 2'h0);
		// clock mode controls follow the straps
		{r_next.clk_div, r_next.bypass, r_next.eq_en, r_next.track,
			r_next.gen_rst, r_next.invalid} = mode_decode(clk_mode_i);
		// system reset aborts any phase of the sequence
		if (!sys_reset_n_i) begin
			r_next.state = reset_seq_pkg::S_HOLD;
			r_next.chip_rst_n = 1'b0;
			r_next.srom_clk = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			r_reg <= '0;
			r_reg.state <= reset_seq_pkg::S_HOLD;
			r_reg.ratio <= 4'h4;
			r_reg.clk_div <= 3'h1;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign srom_clk_o = r_reg.srom_clk;
	assign load_valid_o = r_reg.valid;
	assign load_data_o = r_reg.buf0;
	assign chip_reset_n_o = r_reg.chip_rst_n;
	assign clk_div_o = r_reg.clk_div;
	assign div_bypass_o = r_reg.bypass;
	assign equalizer_en_o = r_reg.eq_en;
	assign ref_track_o = r_reg.track;
	assign system_clock_output_reset_o = r_reg.gen_rst;
	assign clk_mode_invalid_o = r_reg.invalid;

	// checking helpers: independent counts of ticks, cycles and serial gaps
	logic [`SEQ_W-1:0] h_ticks; // system cycles seen in the current phase
	logic [23:0] h_cpu; // processor cycles seen in the current phase
	logic [6:0] h_gap; // cycles since the last serial clock rise, saturating
	// counts stop during a stall, just as the sequencer freezes
	always_ff @(posedge clk_i) begin
		if (!resetn_i || r_reg.state == reset_seq_pkg::S_HOLD || bist_end) begin
			h_ticks <= '0;
			h_cpu <= '0;
		end else if (!stall) begin
			h_ticks <= tick ? h_ticks + `SEQ_W'(1) : h_ticks;
			h_cpu <= h_cpu + 24'h1;
		end
		// the rise cycle counts as one, so a full period reads 126 at the next rise
		if (!resetn_i || (srom_clk_o == 1'b0 && r_next.srom_clk)) begin
			h_gap <= 7'h01;
		end else if (!stall && h_gap != 7'h7F) begin
			h_gap <= h_gap + 7'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// release of the system reset always leads into the self test
	a_bist_start: assert property (
		r_reg.state == reset_seq_pkg::S_HOLD && sys_reset_n_i
		|=> r_reg.state == reset_seq_pkg::S_BIST)
		else $error("self test not started");
	// a low system reset wins over every phase of the sequence
	a_abort_to_hold: assert property (
		!sys_reset_n_i
		|=> r_reg.state == reset_seq_pkg::S_HOLD && !chip_reset_n_o)
		else $error("system reset did not abort");
	// without a boot rom the internal reset goes straight to run
	a_no_rom_release: assert property (
		bist_end && srom_present_n_i && sys_reset_n_i
		|=> chip_reset_n_o && r_reg.state == reset_seq_pkg::S_RUN)
		else $error("reset not released after test");
	// with a boot rom the load opens with a serial clock rise
	a_rom_load_start: assert property (
		bist_end && !srom_present_n_i && sys_reset_n_i
		|=> r_reg.state == reset_seq_pkg::S_LOAD && srom_clk_o)
		else $error("load did not follow test");
	// the internal reset only ever lifts in run
	a_load_holds_reset: assert property (
		r_reg.state != reset_seq_pkg::S_RUN
		|-> !chip_reset_n_o)
		else $error("internal reset released early");
	// a waiting word stays put until the receiver takes it
	a_word_held: assert property (
		load_valid_o && !load_ready_i
		|=> load_valid_o && $stable(load_data_o))
		else $error("loaded word lost");
	// the test count starts fresh on the first edge after release
	a_bist_from_edge: assert property (
		$rose(r_reg.state == reset_seq_pkg::S_BIST)
		|-> r_reg.div == 4'h0 && r_reg.seq == '0)
		else $error("test count not from edge");
	// self test length in system cycles for the captured ratio
	a_bist_length: assert property (
		bist_end
		|-> h_ticks + `SEQ_W'(1) == bist_len(r_reg.ratio))
		else $error("self test length wrong");
	// the serial clock only runs while loading
	a_srom_idle: assert property (
		r_reg.state != reset_seq_pkg::S_LOAD
		|-> !srom_clk_o)
		else $error("serial clock outside load");
	// a rise inside the load closes one full period
	a_srom_period: assert property (
		r_reg.state == reset_seq_pkg::S_LOAD && !srom_clk_o && r_next.srom_clk
		|-> h_gap == 7'h7E)
		else $error("serial clock period wrong");
	// no period may come out shorter than the floor
	a_srom_min: assert property (
		r_reg.state == reset_seq_pkg::S_LOAD && !srom_clk_o && r_next.srom_clk
		|-> h_gap >= 7'h7E - {3'h0, r_reg.ratio})
		else $error("serial clock too short");
	// a full buffer parks the serial clock low where it stands
	a_stall_freeze: assert property (
		stall
		|=> $stable(r_reg.phase) && !srom_clk_o)
		else $error("serial clock moved in stall");
	// load length in system cycles, stalls excluded
	a_load_length: assert property (
		load_end
		|-> h_ticks + `SEQ_W'(1) == load_len(r_reg.ratio))
		else $error("load length wrong");
	// the same load length counted in processor cycles
	a_load_cpu: assert property (
		load_end
		|-> h_cpu + 24'h1 == 24'(load_len(r_reg.ratio)) * 24'(r_reg.ratio))
		else $error("load cycles wrong");
	// normal mode: undivided with the equalizer on
	a_mode_normal: assert property (
		clk_mode_i == `MODE_NORMAL
		|=> equalizer_en_o && clk_div_o == 3'h1)
		else $error("normal mode wrong");
	// double mode: oscillator halved
	a_mode_div2: assert property (
		clk_mode_i == `MODE_DIV2
		|=> clk_div_o == 3'h2)
		else $error("divide by two wrong");
	// chip test: divider bypassed, equalizer off
	a_mode_chip: assert property (
		clk_mode_i == `MODE_CHIPTEST
		|=> div_bypass_o && !equalizer_en_o)
		else $error("chip test mode wrong");
	// module test: quartered and tracking the reference
	a_mode_module: assert property (
		clk_mode_i == `MODE_MODTEST
		|=> clk_div_o == 3'h4 && ref_track_o)
		else $error("module test mode wrong");
	// clock reset mode: output generator held in reset
	a_mode_clkrst: assert property (
		clk_mode_i == `MODE_CLKRST
		|=> system_clock_output_reset_o)
		else $error("clock reset mode wrong");
	// unused strap codes are flagged and fall back to divide by one
	a_mode_invalid: assert property (
		clk_mode_i == 3'h4 || clk_mode_i[2:1] == 2'h3
		|=> clk_mode_invalid_o && clk_div_o == 3'h1)
		else $error("invalid mode not flagged");

	// main scenarios: plain release, full load, stall, abort mid-load, second word
	c_no_rom: cover property (bist_end && srom_present_n_i);
	c_rom_load: cover property (load_end);
	c_stall: cover property (stall);
	c_abort: cover property ((r_reg.state == reset_seq_pkg::S_LOAD) && !sys_reset_n_i);
	c_two_words: cover property (push && r_reg.fill == 2'h1);
endmodule : reset_bist_srom_clkmode

// *** sim/srom_model.sv ***
`timescale 1ns/100ps
module srom_model #(
	parameter int DELAY = 40
) (
	// clock and control
	input wire logic clk_i,
	input wire logic restart_i,
	// serial rom pins
	input wire logic srom_clk_i,
	output logic srom_data_o
);
	logic clk_q = 1'b0; // last serial clock level
	int bit_cnt = 0; // bits sent so far
	int wait_cnt = 0; // cycles until next bit settles

	// byte k of the image is 5A + 33*k, msb first
	function automatic logic pick(input int b);
		logic [7:0] w;
		w = 8'h5A + 8'h33 * b[10:3];
		return w[3'h7 - b[2:0]];
	endfunction : pick

	initial srom_data_o = 1'b0;
	// bit settles late; until then the line shows the inverse, not the old bit
	always @(posedge clk_i) begin
		clk_q <= srom_clk_i;
		if (restart_i) begin
			bit_cnt <= 0;
			wait_cnt <= 0;
		end else if (srom_clk_i && !clk_q) begin
			wait_cnt <= DELAY;
			srom_data_o <= ~srom_data_o;
		end else if (wait_cnt == 1) begin
			srom_data_o <= pick(bit_cnt);
			bit_cnt <= bit_cnt + 1;
			wait_cnt <= 0;
		end else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : srom_model

// *** sim/tb_reset_bist_srom_clkmode.sv ***
`timescale 1ns/100ps
module tb_reset_bist_srom_clkmode;
	// shortened counts, the start and release timing expectations derive from these
	localparam int B3 = 10, B4 = 12, B15 = 6, L3 = 1100, L4 = 800, L15 = 220;
	// inputs
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sys_reset_n_i = 1'b0;
	logic srom_present_n_i = 1'b1;
	logic [3:0] sysclk_ratio_i = 4'h4;
	logic [2:0] clk_mode_i = 3'h5;
	logic load_ready_i = 1'b1;
	logic restart = 1'b1;
	// outputs
	logic srom_data_i, srom_clk_o, load_valid_o, chip_reset_n_o;
	logic [7:0] load_data_o;
	logic [2:0] clk_div_o;
	logic div_bypass_o, equalizer_en_o, ref_track_o;
	logic system_clock_output_reset_o, clk_mode_invalid_o;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] rx_q[$]; // popped words

	reset_bist_srom_clkmode #(.BIST_R3(B3), .BIST_R4(B4), .BIST_R15(B15),
		.LOAD_R3(L3), .LOAD_R4(L4), .LOAD_R15(L15)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .sys_reset_n_i(sys_reset_n_i),
		.srom_present_n_i(srom_present_n_i), .sysclk_ratio_i(sysclk_ratio_i),
		.clk_mode_i(clk_mode_i), .srom_data_i(srom_data_i), .srom_clk_o(srom_clk_o),
		.load_valid_o(load_valid_o), .load_data_o(load_data_o),
		.load_ready_i(load_ready_i), .chip_reset_n_o(chip_reset_n_o),
		.clk_div_o(clk_div_o), .div_bypass_o(div_bypass_o),
		.equalizer_en_o(equalizer_en_o), .ref_track_o(ref_track_o),
		.system_clock_output_reset_o(system_clock_output_reset_o),
		.clk_mode_invalid_o(clk_mode_invalid_o));

	srom_model #(.DELAY(40)) rom (.clk_i(clk_i), .restart_i(restart),
		.srom_clk_i(srom_clk_o), .srom_data_o(srom_data_i));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic finish_test();
		if (n_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// ratios other than 3 and 15 take the ratio-4 length
	function automatic int bist_len(input int r);
		return (r == 3) ? B3 : (r == 15) ? B15 : B4;
	endfunction : bist_len

	// hold system reset, set straps, release at the returning edge
	task automatic start_seq(input logic [3:0] r, input logic rom_n, input logic rdy);
		@(posedge clk_i);
		sys_reset_n_i <= 1'b0;
		restart <= 1'b1;
		sysclk_ratio_i <= r;
		srom_present_n_i <= rom_n;
		load_ready_i <= rdy;
		repeat (3) @(posedge clk_i);
		rx_q.delete();
		sys_reset_n_i <= 1'b1;
		restart <= 1'b0;
	endtask : start_seq

	task automatic check_words();
		check("word_count", 3, rx_q.size());
		for (int k = 0; k < rx_q.size(); k++) begin
			check("word", 8'(8'h5A + 8'h33 * k), rx_q[k]);
		end
	endtask : check_words

	// every strap code, invalid ones included
	task automatic test_modes();
		logic [7:0] exp;
		for (int m = 0; m < 8; m++) begin
			@(posedge clk_i);
			clk_mode_i <= m[2:0];
			repeat (2) @(posedge clk_i);
			#1;
			case (m)
				0: exp = {3'h2, 5'h00};
				1: exp = {3'h1, 5'h10};
				2: exp = {3'h4, 5'h04};
				3: exp = {3'h1, 5'h02};
				5: exp = {3'h1, 5'h08};
				default: exp = {3'h1, 5'h01};
			endcase
			check("clock_mode", exp, {clk_div_o, div_bypass_o, equalizer_en_o, ref_track_o,
				system_clock_output_reset_o, clk_mode_invalid_o});
		end
		@(posedge clk_i);
		clk_mode_i <= 3'h5;
	endtask : test_modes

	// no rom: release right after the self test, serial clock idle
	task automatic test_no_rom(input logic [3:0] r);
		int n;
		logic clk_seen;
		clk_seen = 1'b0;
		start_seq(r, 1'b1, 1'b1);
		for (n = 1; n < 2000; n++) begin
			@(posedge clk_i);
			#1;
			if (srom_clk_o !== 1'b0) clk_seen = 1'b1;
			if (chip_reset_n_o === 1'b1) break;
		end
		check("bist_release", bist_len(r) * r + 1, n);
		check("no_serial_clock", 0, clk_seen);
	endtask : test_no_rom

	// rom present, receiver always ready: exact lengths and clock shape
	task automatic test_rom_timed(input logic [3:0] r, input int ld);
		int n, up, dn, up2;
		up = 0;
		dn = 0;
		up2 = 0;
		start_seq(r, 1'b0, 1'b1);
		for (n = 1; n < 20000; n++) begin
			@(posedge clk_i);
			#1;
			if (chip_reset_n_o === 1'b1) break;
			if (srom_clk_o === 1'b1 && up == 0) up = n;
			if (srom_clk_o === 1'b0 && up != 0 && dn == 0) dn = n;
			if (srom_clk_o === 1'b1 && dn != 0 && up2 == 0) up2 = n;
		end
		check("load_start", bist_len(r) * r + 1, up);
		check("clk_high", 63, dn - up);
		check("clk_period", 126, up2 - up);
		check("load_release", (bist_len(r) + ld) * r + 1, n);
		check_words();
	endtask : test_rom_timed

	// system reset during the load: serial clock and internal reset drop at once
	task automatic test_abort();
		start_seq(4'h4, 1'b0, 1'b1);
		repeat (bist_len(4) * 4 + 137) @(posedge clk_i);
		#1;
		check("abort_clk_before", 1, srom_clk_o);
		@(posedge clk_i);
		sys_reset_n_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("abort_clk", 0, srom_clk_o);
		check("abort_reset", 0, chip_reset_n_o);
	endtask : test_abort

	// receiver stalls: load freezes with reset held, no word lost
	task automatic test_rom_stall(input logic [3:0] r);
		int n, flips;
		logic last;
		flips = 0;
		start_seq(r, 1'b0, 1'b0);
		repeat (bist_len(r) * r + 3100) @(posedge clk_i);
		#1;
		check("stall_valid", 1, load_valid_o);
		check("stall_reset", 0, chip_reset_n_o);
		last = srom_clk_o;
		repeat (130) begin
			@(posedge clk_i);
			#1;
			if (srom_clk_o !== last) flips++;
			last = srom_clk_o;
		end
		check("stall_clock_frozen", 0, flips);
		@(posedge clk_i);
		load_ready_i <= 1'b1;
		for (n = 0; n < 5000 && chip_reset_n_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		check("stall_release", 1, chip_reset_n_o);
		check_words();
	endtask : test_rom_stall

	// pop monitor and hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (load_valid_o === 1'b1 && load_ready_i === 1'b1) rx_q.push_back(load_data_o);
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		test_modes();
		test_no_rom(4'h3);
		test_no_rom(4'h4);
		test_no_rom(4'hF);
		test_no_rom(4'h2);
		test_abort();
		test_rom_timed(4'h4, L4);
		test_rom_timed(4'hF, L15);
		test_rom_stall(4'h3);
		finish_test();
	end
endmodule : tb_reset_bist_srom_clkmode
